// file: pkg/tv_timing_defines.svh
`ifndef TV_TIMING_DEFINES_SVH
`define TV_TIMING_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_PRESCALER   12'h814
`define OFS_DEBUG       12'h818
`define OFS_CTL1        12'hc00
`define OFS_CTL2        12'hc04
`define OFS_STATUS      12'hc60

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_PRESCALER   32'h00000000
`define RST_DEBUG       32'h00000440
`define RST_CTL1        32'h00000000
`define RST_CTL2        32'h1ff00000

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define B_INTERP        10
`define B_FINV          9
`define B_FSRC          7
`define B_FSTAT         6
`define B_TIMING_EN     31
`define B_PSW_INV       30
`define SCR_HI          29
`define SCR_LO          28
`define B_BLANK         27
`define B_BURST_DIS     26
`define B_SETUP         25
`define B_PAL           24
`define B_LINE_SEL      23
`define REF_HI          22
`define REF_LO          21
`define VPH_HI          20
`define VPH_LO          11
`define HPH_HI          10
`define HPH_LO          0
`define B_ANLG          31
`define B_DACM2         30
`define B_LUMA_BP       19
`define B_CHROMA_BP     18
`define LPF_HI          17
`define LPF_LO          16
`define HUE_HI          7
`define HUE_LO          0

// ------------------------------------------------------------
// timing counts: horizontal in 27 MHz video clocks, vertical in lines, plus the frame counter load value
// ------------------------------------------------------------
`define HALF_MAX_PAL    10'd863
`define HALF_MAX_NTSC   10'd857
`define LINES_PAL       10'd625
`define LINES_NTSC      10'd525
`define FIELD2_PAL      10'd313
`define FIELD2_NTSC     10'd263
`define HSYNC_WIDTH     10'd63
`define HBLANK_NORM     10'd138
`define HBLANK_ANLG     10'd150
`define VSYNC_LINES     10'd3
`define VBLANK_LINES    10'd22
`define FRAME_REF_LOAD  2'd3

`endif

// file: pkg/tv_timing_pkg.sv
package tv_timing_pkg;

  // subcarrier reset interval codes
  typedef enum logic [1:0] {
    SC_NEVER,
    SC_TWO_LINES,
    SC_TWO_FRAMES,
    SC_FOUR_FRAMES
  } sc_reset_t;

  // chroma lowpass selection
  typedef logic [1:0] lpf_sel_t;
  typedef logic [7:0] hue_t;
  typedef logic [9:0] count_t;

endpackage

// file: pkg/timing_if.sv
`timescale 1ns/1ns
// control and state between register side and timing generator
interface timing_if;
  import tv_timing_pkg::*;
  logic        enable;
  logic        line_std;
  logic [1:0]  ref_mode;
  logic [10:0] horizontal_phase;
  count_t      vertical_phase;
  logic        ref_pulse;
  count_t      hcount;
  logic        line_half;
  count_t      vcount;
  logic [1:0]  frame_cnt;
  logic        line_end;
  logic        frame_end;
  logic        field;

  modport ctrl (
    output enable, line_std, ref_mode, horizontal_phase, vertical_phase, ref_pulse,
    input  hcount, line_half, vcount, frame_cnt, line_end, frame_end, field
  );
  modport gen (
    input  enable, line_std, ref_mode, horizontal_phase, vertical_phase, ref_pulse,
    output hcount, line_half, vcount, frame_cnt, line_end, frame_end, field
  );
endinterface

// file: design/timing_gen.sv
`timescale 1ns/1ns
`include "tv_timing_defines.svh"

module timing_gen (
  input wire logic clk,
  input wire logic rst,
  timing_if.gen    tif
);
  import tv_timing_pkg::*;

  count_t half_max;
  count_t lines;
  count_t field2;

  // ------------------------------------------------------------
  // line standard dependent limits
  // ------------------------------------------------------------
  assign half_max = tif.line_std ? `HALF_MAX_NTSC : `HALF_MAX_PAL;
  assign lines    = tif.line_std ? `LINES_NTSC : `LINES_PAL;
  assign field2   = tif.line_std ? `FIELD2_NTSC : `FIELD2_PAL;

  // end-of-line and end-of-frame strobes
  assign tif.line_end  = tif.enable && tif.line_half && (tif.hcount == half_max);
  assign tif.frame_end = tif.line_end && (tif.vcount == lines);
  assign tif.field     = (tif.vcount >= field2);

  // ------------------------------------------------------------
  // horizontal counter: half-line count plus line-half flag
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tif.hcount    <= '0;
      tif.line_half <= 1'b0;
    end
    else if (tif.ref_pulse && tif.ref_mode[0])
    begin
      tif.hcount    <= tif.horizontal_phase[9:0];
      tif.line_half <= tif.horizontal_phase[10];
    end
    else if (tif.enable)
    begin
      if (tif.hcount == half_max)
      begin
        tif.hcount    <= '0;
        tif.line_half <= ~tif.line_half;
      end
      else
        tif.hcount <= tif.hcount + 10'd1;
    end
  end

  // ------------------------------------------------------------
  // vertical line counter, runs 1 to lines
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      tif.vcount <= 10'd1;
    else if (tif.ref_pulse && tif.ref_mode[0])
      tif.vcount <= tif.vertical_phase;
    else if (tif.frame_end)
      tif.vcount <= 10'd1;
    else if (tif.line_end)
      tif.vcount <= tif.vcount + 10'd1;
  end

  // ------------------------------------------------------------
  // frame counter, modulo four
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      tif.frame_cnt <= 2'd0;
    else if (tif.ref_pulse && tif.ref_mode[1])
      tif.frame_cnt <= `FRAME_REF_LOAD;
    else if (tif.frame_end)
      tif.frame_cnt <= tif.frame_cnt + 2'd1;
  end

endmodule

// file: design/tv_encoder_timing_control.sv
`timescale 1ns/1ns
`include "tv_timing_defines.svh"
// Behaviour
// - scaler interpolates when interp bit is 1, replicates pixels when 0
// - field invert bit, default 0, inverts reported field when 1
// - field source: 0 encoder timing generator, 1 output-stage generator
// - timing enable 0 stops counters, disables syncs, asserts blank
// - phase switch invert bit flips alternating-line PAL switch sense
// - subcarrier reset: never, every two lines, two frames, four frames
// - blank bit blanks video output regardless of picture
// - burst disable 1 suppresses color burst, 0 inserts it
// - pedestal bit adds 7.5 IRE offset with rescale
// - color standard bit: 0 NTSC encoding, 1 PAL encoding
// - line standard bit 1 selects 525-line 60 Hz timing
// - frame reference mode: none, load h/v, frame to 3, or both
// - mode low bit loads vertical counter from vertical phase
// - mode low bit loads horizontal counter from horizontal phase
// - horizontal counter is 10-bit half-line count plus toggling flag
// - PAL line 1728 clocks, half-line counter 0 to 863
// - NTSC line 1716 clocks, half-line modulus 858
// - analog line bit lengthens horizontal blanking
// - holds DAC ordering mode top bit
// - separate luma and chroma oversampling bypass bits
// - chroma lowpass: bypass, 1.3 MHz composite, 1.8 MHz separated
// - hue offset added to subcarrier phase only in active video

module tv_encoder_timing_control (
  input  wire logic               SYS_CLK,
  input  wire logic               SYS_RST,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [11:0]        PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic                    PREADY,
  output logic [31:0]             PRDATA,
  output logic                    PSLVERR,
  input  wire logic               EXTERNAL_FRAME_REFERENCE,
  input  wire logic               OUTPUT_STAGE_FIELD,
  output logic                    SCALER_INTERP,
  output logic                    FIELD_OUT,
  output logic                    HSYNC_OUT,
  output logic                    VSYNC_OUT,
  output logic                    BLANK_OUT,
  output logic                    SUBCARRIER_RESET,
  output logic                    PHASE_SWITCH,
  output logic                    BURST_ENABLE,
  output logic                    PEDESTAL_ENABLE,
  output logic                    PAL_ENCODE,
  output logic                    DAC_MODE_MSB,
  output logic                    LUMA_BYPASS,
  output logic                    CHROMA_BYPASS,
  output tv_timing_pkg::lpf_sel_t CHROMA_LPF_SEL,
  output tv_timing_pkg::hue_t     HUE_PHASE_ADD
);
  import tv_timing_pkg::*;

  logic [31:0] prescaler_reg;
  logic [31:0] debug_reg;
  logic [31:0] ctl1_reg;
  logic [31:0] ctl2_reg;
  logic        ext_ref_reg;
  logic [31:0] rdata_next;
  logic        hit_next;
  logic        wr_take;
  logic        field_now;
  logic        hblank;
  logic        vblank;
  logic        active;
  logic        sc_pulse;
  count_t      hblank_end;
  sc_reset_t   sc_mode;

  timing_if tif ();

  // ------------------------------------------------------------
  // timing generator
  // ------------------------------------------------------------
  timing_gen u_gen (
    .clk (SYS_CLK),
    .rst (SYS_RST),
    .tif (tif.gen)
  );

  // controls handed to the generator
  assign tif.enable    = ctl1_reg[`B_TIMING_EN];
  assign tif.line_std  = ctl1_reg[`B_LINE_SEL];
  assign tif.ref_mode  = ctl1_reg[`REF_HI:`REF_LO];
  assign tif.horizontal_phase    = ctl1_reg[`HPH_HI:`HPH_LO];
  assign tif.vertical_phase    = ctl1_reg[`VPH_HI:`VPH_LO];
  assign tif.ref_pulse = EXTERNAL_FRAME_REFERENCE && !ext_ref_reg;

  // rising edge detect of the frame reference
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      ext_ref_reg <= 1'b0;
    else
      ext_ref_reg <= EXTERNAL_FRAME_REFERENCE;
  end

  // ------------------------------------------------------------
  // apb slave: zero wait state, ready registered at the end of setup, high in the access cycle
  // ------------------------------------------------------------
  assign wr_take = PSEL && PENABLE && PREADY && PWRITE;

  // read mux and address decode
  always_comb
  begin
    rdata_next = 32'h00000000;
    hit_next   = 1'b1;
    case (PADDR)
      `OFS_PRESCALER: rdata_next = prescaler_reg;
      `OFS_DEBUG:
      begin
        rdata_next            = debug_reg;
        rdata_next[`B_FSTAT]  = field_now;
      end
      `OFS_CTL1:      rdata_next = ctl1_reg;
      `OFS_CTL2:      rdata_next = ctl2_reg;
      `OFS_STATUS:
        rdata_next = {tif.line_half, tif.frame_cnt, 3'h0, tif.vcount, 6'h00, tif.hcount};
      default:        hit_next = 1'b0;
    endcase
  end

  // answer is captured in the setup cycle
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end
    else if (PSEL && !PENABLE)
    begin
      PREADY  <= 1'b1;
      PRDATA  <= PWRITE ? 32'h00000000 : rdata_next;
      PSLVERR <= !hit_next;
    end
    else
    begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  // scaler control
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      prescaler_reg <= `RST_PRESCALER;
    else if (wr_take && PADDR == `OFS_PRESCALER)
      prescaler_reg <= PWDATA;
  end

  // output stage debug, field status bit is read only
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      debug_reg <= `RST_DEBUG;
    else if (wr_take && PADDR == `OFS_DEBUG)
    begin
      debug_reg            <= PWDATA;
      debug_reg[`B_FSTAT]  <= debug_reg[`B_FSTAT];
    end
  end

  // timing and encoder control one
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      ctl1_reg <= `RST_CTL1;
    else if (wr_take && PADDR == `OFS_CTL1)
      ctl1_reg <= PWDATA;
  end

  // timing and encoder control two
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      ctl2_reg <= `RST_CTL2;
    else if (wr_take && PADDR == `OFS_CTL2)
      ctl2_reg <= PWDATA;
  end

  // ------------------------------------------------------------
  // field, blanking and subcarrier decode
  // ------------------------------------------------------------
  assign field_now = (debug_reg[`B_FSRC] ? OUTPUT_STAGE_FIELD : tif.field)
                     ^ debug_reg[`B_FINV];
  assign hblank_end = ctl2_reg[`B_ANLG] ? `HBLANK_ANLG : `HBLANK_NORM;
  assign hblank     = !tif.line_half && (tif.hcount < hblank_end);
  assign vblank     = (tif.vcount <= `VBLANK_LINES);
  assign active     = tif.enable && !ctl1_reg[`B_BLANK] && !hblank && !vblank;
  assign sc_mode    = sc_reset_t'(ctl1_reg[`SCR_HI:`SCR_LO]);

  // subcarrier reset strobe selection
  always_comb
  begin
    case (sc_mode)
      SC_NEVER:       sc_pulse = 1'b0;
      SC_TWO_LINES:   sc_pulse = tif.line_end && tif.vcount[0];
      SC_TWO_FRAMES:  sc_pulse = tif.frame_end && tif.frame_cnt[0];
      SC_FOUR_FRAMES: sc_pulse = tif.frame_end && (tif.frame_cnt == 2'd3);
      default:        sc_pulse = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // registered video outputs
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      FIELD_OUT        <= 1'b0;
      HSYNC_OUT        <= 1'b0;
      VSYNC_OUT        <= 1'b0;
      BLANK_OUT        <= 1'b1;
      SUBCARRIER_RESET <= 1'b0;
      PHASE_SWITCH     <= 1'b0;
      BURST_ENABLE     <= 1'b0;
      HUE_PHASE_ADD    <= 8'h00;
    end
    else
    begin
      FIELD_OUT        <= field_now;
      HSYNC_OUT        <= tif.enable && !tif.line_half && (tif.hcount < `HSYNC_WIDTH);
      VSYNC_OUT        <= tif.enable && (tif.vcount <= `VSYNC_LINES);
      BLANK_OUT        <= !active;
      SUBCARRIER_RESET <= sc_pulse;
      PHASE_SWITCH     <= tif.vcount[0] ^ ctl1_reg[`B_PSW_INV];
      BURST_ENABLE     <= tif.enable && !ctl1_reg[`B_BURST_DIS] && hblank;
      HUE_PHASE_ADD    <= active ? ctl2_reg[`HUE_HI:`HUE_LO] : 8'h00;
    end
  end

  // static encoder controls
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      SCALER_INTERP   <= 1'b0;
      PEDESTAL_ENABLE <= 1'b0;
      PAL_ENCODE      <= 1'b0;
      DAC_MODE_MSB    <= 1'b0;
      LUMA_BYPASS     <= 1'b0;
      CHROMA_BYPASS   <= 1'b0;
      CHROMA_LPF_SEL  <= 2'h0;
    end
    else
    begin
      SCALER_INTERP   <= prescaler_reg[`B_INTERP];
      PEDESTAL_ENABLE <= ctl1_reg[`B_SETUP];
      PAL_ENCODE      <= ctl1_reg[`B_PAL];
      DAC_MODE_MSB    <= ctl2_reg[`B_DACM2];
      LUMA_BYPASS     <= ctl2_reg[`B_LUMA_BP];
      CHROMA_BYPASS   <= ctl2_reg[`B_CHROMA_BP];
      CHROMA_LPF_SEL  <= ctl2_reg[`LPF_HI:`LPF_LO];
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  chk_interp_write: assert property (
    (wr_take && PADDR == `OFS_PRESCALER) |=> ##1 SCALER_INTERP == $past(PWDATA[`B_INTERP], 2))
    else $error("scaler interpolation output does not follow write");

  chk_field_report: assert property (
    ##1 FIELD_OUT == ($past(debug_reg[`B_FSRC]) ? $past(OUTPUT_STAGE_FIELD) : $past(tif.field))
                     ^ $past(debug_reg[`B_FINV]))
    else $error("reported field wrong for source and invert");

  chk_timing_stop: assert property (
    (!ctl1_reg[`B_TIMING_EN] && !tif.ref_pulse) |=>
      $stable(tif.hcount) && BLANK_OUT && !HSYNC_OUT && !VSYNC_OUT)
    else $error("timing not held while disabled");

  chk_half_wrap: assert property (
    (tif.enable && !(tif.ref_pulse && tif.ref_mode[0]) &&
     tif.hcount == (tif.line_std ? `HALF_MAX_NTSC : `HALF_MAX_PAL))
      |=> tif.hcount == 10'd0 && tif.line_half != $past(tif.line_half))
    else $error("half-line counter wrap wrong");

  chk_frame_load: assert property (
    (tif.ref_pulse && tif.ref_mode[1]) |=> tif.frame_cnt == 2'd3)
    else $error("frame counter not set to three");

  chk_phase_load: assert property (
    (tif.ref_pulse && tif.ref_mode[0]) |=>
      tif.vcount == $past(tif.vertical_phase) && tif.hcount == $past(tif.horizontal_phase[9:0])
      && tif.line_half == $past(tif.horizontal_phase[10]))
    else $error("phase load wrong");

  chk_sc_never: assert property (
    (sc_mode == SC_NEVER) |=> !SUBCARRIER_RESET)
    else $error("subcarrier reset while set to never");

  chk_burst_off: assert property (
    ctl1_reg[`B_BURST_DIS] |=> !BURST_ENABLE)
    else $error("burst present while disabled");

  chk_blank_bit: assert property (
    ctl1_reg[`B_BLANK] |=> BLANK_OUT && HUE_PHASE_ADD == 8'h00)
    else $error("output not blanked");

  chk_hue_active: assert property (
    (HUE_PHASE_ADD != 8'h00) |-> !BLANK_OUT)
    else $error("hue added outside active video");

  chk_apb_ready: assert property (
    (PSEL && !PENABLE) |=> PREADY ##1 !PREADY)
    else $error("ready not one cycle after setup");

  chk_lpf_write: assert property (
    (wr_take && PADDR == `OFS_CTL2) |=> ##1 CHROMA_LPF_SEL == $past(PWDATA[`LPF_HI:`LPF_LO], 2))
    else $error("chroma lowpass select does not follow write");

  chk_dac_write: assert property (
    (wr_take && PADDR == `OFS_CTL2) |=> ##1 DAC_MODE_MSB == $past(PWDATA[`B_DACM2], 2)
      && LUMA_BYPASS == $past(PWDATA[`B_LUMA_BP], 2)
      && CHROMA_BYPASS == $past(PWDATA[`B_CHROMA_BP], 2))
    else $error("dac mode or bypass bits do not follow write");

  chk_encode_write: assert property (
    (wr_take && PADDR == `OFS_CTL1) |=> ##1 PAL_ENCODE == $past(PWDATA[`B_PAL], 2)
      && PEDESTAL_ENABLE == $past(PWDATA[`B_SETUP], 2))
    else $error("encoding controls do not follow write");

  chk_frame_wrap: assert property (
    (tif.frame_end && !(tif.ref_pulse && tif.ref_mode[0])) |=> tif.vcount == 10'd1)
    else $error("line counter did not restart after last line");

  chk_sc_lines: assert property (
    (sc_mode == SC_TWO_LINES && tif.line_end && tif.vcount[0]) |=> SUBCARRIER_RESET)
    else $error("subcarrier reset missing after odd line");

  cov_ref_load:  cover property (tif.ref_pulse && tif.ref_mode == 2'd3);
  cov_sc_pulse:  cover property (SUBCARRIER_RESET);
  cov_field_chg: cover property (tif.field != $past(tif.field));
  cov_active:    cover property (!BLANK_OUT ##1 BLANK_OUT);
  cov_sc_lines:  cover property (sc_mode == SC_TWO_LINES && SUBCARRIER_RESET);

endmodule

// file: dv/tv_display_model.sv
`timescale 1ns/1ns
// display side: frame reference source and line length meter
module tv_display_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsync,
  input  wire logic        fire,
  output logic             frame_ref,
  output logic [11:0]      line_len
);
  logic        hs_d;
  logic [11:0] run_cnt;

  // reference follows the request one clock later
  always_ff @(posedge clk)
  begin
    frame_ref <= rst ? 1'b0 : fire;
  end

  // clocks between sync leading edges
  always_ff @(posedge clk)
  begin
    hs_d    <= hsync;
    run_cnt <= (hsync && !hs_d) ? 12'h001 : run_cnt + 12'h001;
    if (hsync && !hs_d)
      line_len <= run_cnt;
  end
endmodule

// file: dv/tv_encoder_timing_control_tb.sv
`timescale 1ns/1ns
`include "tv_timing_defines.svh"
module tv_encoder_timing_control_tb;
  import tv_timing_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, line_len;
  logic [31:0] pwdata, prdata, rd;
  logic        ext_ref, os_field, fire, interp, field, hsync, vsync, blank;
  logic        sc_rst, psw, burst, ped, pal, dac2, ybp, cbp, err;
  lpf_sel_t    lpf;
  hue_t        hue;
  int          err_count, compares, n_bl, n_bu, n_hu, n_sc, n_hs, n_vs;
  localparam logic [31:0] VT   = 32'h80000000;  // timing on
  localparam logic [31:0] L525 = 32'h00800000;  // 525 lines
  localparam logic [31:0] R01  = 32'h00200000;  // load h and v
  localparam logic [31:0] V100 = 32'h00032000;  // vertical phase 100

  tv_encoder_timing_control dut_u (
    .SYS_CLK                  (sys_clk),
    .SYS_RST                  (sys_rst),
    .PSEL                     (psel),
    .PENABLE                  (penable),
    .PWRITE                   (pwrite),
    .PADDR                    (paddr),
    .PWDATA                   (pwdata),
    .PREADY                   (pready),
    .PRDATA                   (prdata),
    .PSLVERR                  (pslverr),
    .EXTERNAL_FRAME_REFERENCE (ext_ref),
    .OUTPUT_STAGE_FIELD       (os_field),
    .SCALER_INTERP            (interp),
    .FIELD_OUT                (field),
    .HSYNC_OUT                (hsync),
    .VSYNC_OUT                (vsync),
    .BLANK_OUT                (blank),
    .SUBCARRIER_RESET         (sc_rst),
    .PHASE_SWITCH             (psw),
    .BURST_ENABLE             (burst),
    .PEDESTAL_ENABLE          (ped),
    .PAL_ENCODE               (pal),
    .DAC_MODE_MSB             (dac2),
    .LUMA_BYPASS              (ybp),
    .CHROMA_BYPASS            (cbp),
    .CHROMA_LPF_SEL           (lpf),
    .HUE_PHASE_ADD            (hue)
  );

  tv_display_model model_u (
    .clk       (sys_clk),
    .rst       (sys_rst),
    .hsync     (hsync),
    .fire      (fire),
    .frame_ref (ext_ref),
    .line_len  (line_len)
  );

  always #25 sys_clk = ~sys_clk;

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 16 && pready !== 1'b1; i++)
      @(posedge sys_clk);
    if (pready !== 1'b1)
    begin
      check("pready", 32'h0, 32'h1);
      stop_test();
    end
    else
    begin
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic settle();
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic pulse_ref();
    fire <= 1'b1;
    repeat (2) @(posedge sys_clk);
    fire <= 1'b0;
    settle();
  endtask

  // count output activity over n clocks
  task automatic run(input int n);
    n_bl = 0;
    n_bu = 0;
    n_hu = 0;
    n_sc = 0;
    n_hs = 0;
    n_vs = 0;
    repeat (n)
    begin
      @(posedge sys_clk);
      n_bl += blank;
      n_bu += burst;
      n_hu += (hue !== 8'h00);
      n_sc += sc_rst;
      n_hs += hsync;
      n_vs += vsync;
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, `OFS_PRESCALER, 32'h0);
    check("prescaler", rd, `RST_PRESCALER);
    apb(1'b0, `OFS_DEBUG, 32'h0);
    check("debug", rd & 32'hffffffbf, `RST_DEBUG & 32'hffffffbf);
    apb(1'b0, `OFS_CTL1, 32'h0);
    check("ctl1", rd, `RST_CTL1);
    apb(1'b0, `OFS_CTL2, 32'h0);
    check("ctl2", rd, `RST_CTL2);
    apb(1'b1, 12'h81c, 32'hffffffff);
    check("unmapped wr", err, 1'b1);
    apb(1'b0, 12'h81c, 32'h0);
    check("unmapped err", err, 1'b1);
    check("unmapped rd", rd, 32'h0);
    run(200);
    check("stopped blank", n_bl, 200);
    check("stopped sync", n_hs, 0);
    check("stopped vsync", n_vs, 0);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("stopped count", rd, 32'h00010000);
  endtask

  task automatic t_regs();
    apb(1'b1, `OFS_PRESCALER, 32'h00000400);
    settle();
    check("interp on", interp, 1'b1);
    apb(1'b1, `OFS_PRESCALER, 32'h0);
    settle();
    check("interp off", interp, 1'b0);
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, `OFS_CTL2, 32'h7ff00000 | (c << 16) | (c << 18));
      settle();
      check("lpf", lpf, c[1:0]);
      check("luma bypass", ybp, c[1]);
      check("chroma bypass", cbp, c[0]);
      check("dac msb", dac2, 1'b1);
    end
    apb(1'b1, `OFS_CTL2, `RST_CTL2);
    settle();
    check("dac msb off", dac2, 1'b0);
  endtask

  task automatic t_load();
    logic [31:0] w [4] = '{32'h00464005, 32'h002c8488, 32'h00003807, 32'h0063200a};
    logic [31:0] e [4] = '{32'h60010000, 32'he1900088, 32'he1900088, 32'h6064000a};
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, `OFS_CTL1, w[i]);
      pulse_ref();
      apb(1'b0, `OFS_STATUS, 32'h0);
      check("ref load", rd, e[i]);
    end
  endtask

  task automatic t_field();
    apb(1'b1, `OFS_CTL1, R01 | 32'h0009c800);
    pulse_ref();
    check("field enc", field, 1'b1);
    check("switch", psw, 1'b1);
    apb(1'b1, `OFS_CTL1, R01 | 32'h4009c800);
    settle();
    check("switch inv", psw, 1'b0);
    apb(1'b1, `OFS_DEBUG, 32'h00000600);
    settle();
    check("field inv", field, 1'b0);
    os_field <= 1'b1;
    apb(1'b1, `OFS_DEBUG, 32'h00000480);
    settle();
    check("field ext", field, 1'b1);
    apb(1'b1, `OFS_DEBUG, 32'h00000680);
    settle();
    check("field ext inv", field, 1'b0);
    os_field <= 1'b0;
    apb(1'b1, `OFS_DEBUG, `RST_DEBUG);
  endtask

  task automatic t_video(input logic [31:0] mode, input int len);
    apb(1'b1, `OFS_CTL2, 32'h1ff000a5);
    apb(1'b1, `OFS_CTL1, VT | mode | R01 | V100);
    pulse_ref();
    run(2 * len);
    run(2 * len);
    check("line length", line_len, len);
    check("blank std", n_bl, 276);
    check("hsync", n_hs, 126);
    check("hue active", n_hu, 2 * len - 276);
    check("burst on", n_bu != 0, 1'b1);
    check("no sc reset", n_sc, 0);
    check("pal enc", pal, mode[24]);
    check("pedestal", ped, mode[25]);
    apb(1'b1, `OFS_CTL2, 32'h9ff000a5);
    settle();
    run(2 * len);
    check("blank anlg", n_bl, 300);
    apb(1'b1, `OFS_CTL1, VT | mode | R01 | V100 | 32'h04000000);
    settle();
    run(2 * len);
    check("burst off", n_bu, 0);
    apb(1'b1, `OFS_CTL1, VT | mode | R01 | V100 | 32'h08000000);
    settle();
    run(len);
    check("blanked", n_bl, len);
    check("hue blanked", n_hu, 0);
  endtask

  task automatic t_sc();
    apb(1'b1, `OFS_CTL1, VT | L525 | 32'h10000000 | R01 | V100);
    pulse_ref();
    run(4 * 1716);
    check("sc two lines", n_sc, 2);
    for (int c = 2; c < 4; c++)
    begin
      apb(1'b1, `OFS_CTL1, VT | L525 | (c << 28) | 32'h00706800);
      pulse_ref();
      run(1800);
      check("sc frames", n_sc, 1);
      check("vsync", n_vs, 86);
    end
  endtask

  initial
  begin
    sys_clk   = 1'b0;
    sys_rst   = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    os_field  = 1'b0;
    fire      = 1'b0;
    err_count = 0;
    compares  = 0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_regs();
    t_load();
    t_field();
    t_video(L525, 1716);
    t_video(32'h03000000, 1728);
    t_sc();
    stop_test();
  end
endmodule
